//--- hdl/homing_pkg.sv
package homing_pkg;
  // ---------------------------------------------------------------
  // register map (word index, byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_SINGLE = 4'h1;
  localparam logic [3:0] REG_MULTI = 4'h2;
  localparam logic [3:0] REG_APPROACH = 4'h3;
  localparam logic [3:0] REG_LEAVE = 4'h4;
  localparam logic [3:0] REG_OFS_HI = 4'h5;
  localparam logic [3:0] REG_OFS_LO = 4'h6;
  localparam logic [3:0] REG_ACCEL = 4'h7;
  localparam logic [3:0] REG_MODE = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [3:0] REG_OFFSET = 4'hA;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CFG_ENABLE = 0;
  localparam int CFG_TRIGGER = 1;
  localparam int CFG_STORAGE = 2;
  localparam int CFG_LIMIT = 3;
  localparam int CFG_ENC_TYPE = 4;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] APPROACH_RESET = 16'h05DC;
  localparam logic [15:0] LEAVE_RESET = 16'h001E;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] ACCEL_RESET = 16'h0064;
  localparam logic [15:0] ORIGIN_RESET = 16'h0000;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [15:0] APPROACH_MAX = 16'h0BB8;
  localparam logic [15:0] LEAVE_MAX = 16'h00C8;
  localparam logic [15:0] ACCEL_MAX = 16'h1388;
  localparam logic [15:0] OFS_MAX = 16'h270F;
  localparam logic [15:0] RPM_REF = 16'h03E8;
  localparam logic [31:0] OFS_SCALE = 32'h0000_2710;
  localparam logic [3:0] MODE_LAST_SWITCH = 4'h6;
  localparam logic [3:0] MODE_LAST = 4'hA;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLOCK_HZ = 20000000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_APPROACH, ST_LEAVE, ST_OFFSET, ST_LIMIT
  } home_state_t;

  typedef struct packed {
    logic start;
    logic origin;
    logic fwd_ot;
    logic rev_ot;
    logic index;
  } pins_t;

  typedef struct packed {
    logic [31:0] position;
    logic position_load;
    logic signed [16:0] speed;
    logic homing_busy;
    logic homing_done;
    logic limit_state;
  } motion_t;
endpackage : homing_pkg

//--- hdl/servo_homing_sequencer.sv
// The placing of the registers and the Avalon-MM slave port were decided locally.
module servo_homing_sequencer
  import homing_pkg::*;
#(
  parameter int SYNC_DEPTH = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // drive context (same clock domain)
  input wire logic power_up,
  input wire logic servo_on,
  input wire logic position_mode,
  input wire logic positioning_complete_output,
  input wire logic [31:0] encoder_position,
  // external pins (asynchronous)
  input wire homing_pkg::pins_t pins,
  // motion outputs
  output homing_pkg::motion_t motion
);
  import homing_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int NPIN = $bits(pins_t);
  logic [NPIN-1:0] sync_q [SYNC_DEPTH];   // shift chain per stage
  logic [NPIN-1:0] sync_d [SYNC_DEPTH];
  logic [NPIN-1:0] pin_q, pin_d;          // agreed level

  // chain: stage 0 only feeds stage 1
  always_comb begin
    sync_d[0] = pins;
    for (int i = 1; i < SYNC_DEPTH; i++) begin
      sync_d[i] = sync_q[i-1];
    end
    pin_d = pin_q;
    // change counts once stages one and two agree
    for (int b = 0; b < NPIN; b++) begin
      if (sync_q[1][b] == sync_q[2][b]) begin
        pin_d[b] = sync_q[2][b];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < SYNC_DEPTH; i++) begin
        sync_q[i] <= '0;
      end
      pin_q <= '0;
    end else begin
      sync_q <= sync_d;
      pin_q <= pin_d;
    end
  end

  pins_t pin_s;
  assign pin_s = pins_t'(pin_q);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] cfg_q, cfg_d;              // written config
  logic [15:0] cfg_act_q, cfg_act_d;      // config in force
  logic [3:0] mode_q, mode_d;             // written mode
  logic [3:0] mode_act_q, mode_act_d;     // mode in force
  logic [15:0] single_q, single_d;        // stored single-turn origin
  logic [15:0] multi_q, multi_d;          // stored multi-turn origin
  logic [15:0] appr_q, appr_d;            // approach speed rpm
  logic [15:0] leave_q, leave_d;          // leave speed rpm
  logic signed [15:0] ofs_hi_q, ofs_hi_d; // offset high part
  logic signed [15:0] ofs_lo_q, ofs_lo_d; // offset low part
  logic [15:0] accel_q, accel_d;          // ramp time ms
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;                   // answer one cycle late
  home_state_t state_q, state_d;          // sequencer state
  logic [31:0] offset_q, offset_d;        // signed offset pulses

  logic wr_acc, rd_acc;
  logic done_pulse;                       // homing finished this cycle

  // clamp helpers for ranged fields
  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] mx);
    clamp_u = (v > mx) ? mx : v;
  endfunction : clamp_u

  function automatic logic [15:0] clamp_s(input logic [15:0] v);
    logic signed [15:0] s;
    s = signed'(v);
    if (s > signed'(OFS_MAX)) begin
      clamp_s = OFS_MAX;
    end else if (s < -signed'(OFS_MAX)) begin
      clamp_s = -OFS_MAX;
    end else begin
      clamp_s = v;
    end
  endfunction : clamp_s

  assign wr_acc = write && !wait_q;
  // read data captured at the end of the waitrequest-high cycle so it stands while waitrequest is low
  assign rd_acc = read && wait_q;

  // next register values and read mux
  always_comb begin
    cfg_d = cfg_q;
    mode_d = mode_q;
    single_d = single_q;
    multi_d = multi_q;
    appr_d = appr_q;
    leave_d = leave_q;
    ofs_hi_d = ofs_hi_q;
    ofs_lo_d = ofs_lo_q;
    accel_d = accel_q;
    cfg_act_d = cfg_act_q;
    mode_act_d = mode_act_q;
    rdata_d = rdata_q;
    // first cycle of each request waits, second answers
    wait_d = (read || write) ? wait_q : 1'b1;
    if ((read || write) && wait_q) begin
      wait_d = 1'b0;
    end else if (!wait_q) begin
      wait_d = 1'b1;
    end
    if (wr_acc && (&byteenable[1:0])) begin
      case (address[5:2])
        REG_CONFIG: cfg_d = writedata[15:0];
        REG_MODE: mode_d = (writedata[3:0] > MODE_LAST) ? MODE_LAST : writedata[3:0];
        REG_SINGLE: single_d = writedata[15:0];
        REG_MULTI: multi_d = writedata[15:0];
        REG_APPROACH: appr_d = clamp_u(writedata[15:0], APPROACH_MAX);
        REG_LEAVE: leave_d = clamp_u(writedata[15:0], LEAVE_MAX);
        REG_OFS_HI: ofs_hi_d = clamp_s(writedata[15:0]);
        REG_OFS_LO: ofs_lo_d = clamp_s(writedata[15:0]);
        REG_ACCEL: accel_d = clamp_u(writedata[15:0], ACCEL_MAX);
        default: ;
      endcase
    end
    // configuration takes effect at power-up only
    if (power_up) begin
      cfg_act_d = cfg_q;
      mode_act_d = mode_q;
    end
    // origin storage after homing
    if (!cfg_act_q[CFG_STORAGE]) begin
      single_d = ORIGIN_RESET;
      multi_d = ORIGIN_RESET;
    end else if (done_pulse) begin
      single_d = encoder_position[15:0];
      multi_d = encoder_position[31:16];
    end
    if (rd_acc) begin
      case (address[5:2])
        REG_CONFIG: rdata_d = {16'h0000, cfg_q};
        REG_MODE: rdata_d = {28'h0000000, mode_q};
        REG_SINGLE: rdata_d = {16'h0000, single_q};
        REG_MULTI: rdata_d = {16'h0000, multi_q};
        REG_APPROACH: rdata_d = {16'h0000, appr_q};
        REG_LEAVE: rdata_d = {16'h0000, leave_q};
        REG_OFS_HI: rdata_d = {16'h0000, ofs_hi_q};
        REG_OFS_LO: rdata_d = {16'h0000, ofs_lo_q};
        REG_ACCEL: rdata_d = {16'h0000, accel_q};
        REG_STATUS: rdata_d = {24'h000000, 2'b00, motion.limit_state, motion.homing_done,
                               motion.homing_busy, 3'(state_q)};
        REG_OFFSET: rdata_d = offset_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= CONFIG_RESET;
      cfg_act_q <= CONFIG_RESET;
      mode_q <= MODE_RESET;
      mode_act_q <= MODE_RESET;
      single_q <= ORIGIN_RESET;
      multi_q <= ORIGIN_RESET;
      appr_q <= APPROACH_RESET;
      leave_q <= LEAVE_RESET;
      ofs_hi_q <= OFFSET_RESET;
      ofs_lo_q <= OFFSET_RESET;
      accel_q <= ACCEL_RESET;
      rdata_q <= 32'h0000_0000;
      wait_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      cfg_act_q <= cfg_act_d;
      mode_q <= mode_d;
      mode_act_q <= mode_act_d;
      single_q <= single_d;
      multi_q <= multi_d;
      appr_q <= appr_d;
      leave_q <= leave_d;
      ofs_hi_q <= ofs_hi_d;
      ofs_lo_q <= ofs_lo_d;
      accel_q <= accel_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;

  // ---------------------------------------------------------------
  // homing sequencer
  // ---------------------------------------------------------------
  logic start_prev_q, start_prev_d;       // edge detect of start
  logic servo_prev_q, servo_prev_d;       // edge detect of servo-on
  logic dir_q, dir_d;                     // 1 = forward
  logic [31:0] pos_q, pos_d;              // commanded position
  logic load_q, load_d;
  logic done_q, done_d;
  logic signed [16:0] spd_q, spd_d;       // ramped speed rpm
  logic [31:0] tick_q, tick_d;            // ramp step timer
  logic [31:0] ofs_left_q, ofs_left_d;    // offset pulses left
  logic trig, allowed, limit_hit, origin_hit, fwd_mode;
  logic [15:0] target;
  logic [31:0] step_cycles;

  assign fwd_mode = mode_act_q[0];        // odd modes go forward
  assign limit_hit = dir_q ? pin_s.fwd_ot : pin_s.rev_ot;
  // origin source per mode: switch for 0-2, overtravel for 7-8, else index
  assign origin_hit = (mode_act_q <= 4'h2) ? pin_s.origin :
                      (mode_act_q >= 4'h7 && mode_act_q <= 4'h8) ? limit_hit : pin_s.index;
  assign trig = (pin_s.start && !start_prev_q) ||
                (cfg_act_q[CFG_TRIGGER] && servo_on && !servo_prev_q);
  assign allowed = cfg_act_q[CFG_ENABLE] && position_mode && positioning_complete_output &&
                   !(servo_on && (pin_s.fwd_ot || pin_s.rev_ot));
  // cycles per 1 rpm step: accel ms * cycles/ms / 1000 rpm
  assign step_cycles = (32'(accel_q) * 32'(CYCLES_PER_MS)) / 32'(RPM_REF);
  assign target = (state_q == ST_APPROACH) ? appr_q : leave_q;
  assign done_pulse = done_d && !done_q;

  always_comb begin
    state_d = state_q;
    start_prev_d = pin_s.start;
    servo_prev_d = servo_on;
    dir_d = dir_q;
    offset_d = 32'(signed'(ofs_hi_q)) * OFS_SCALE + 32'(signed'(ofs_lo_q));
    pos_d = pos_q;
    load_d = 1'b0;
    done_d = 1'b0;
    spd_d = spd_q;
    tick_d = tick_q;
    ofs_left_d = ofs_left_q;
    // speed ramp toward target in moving states
    if (state_q == ST_APPROACH || state_q == ST_LEAVE) begin
      if (step_cycles == 32'h0 || tick_q >= step_cycles) begin
        tick_d = 32'h0;
        if (17'(target) > (spd_q < 0 ? -spd_q : spd_q)) begin
          spd_d = dir_q ? spd_q + 17'sd1 : spd_q - 17'sd1;
        end else begin
          spd_d = dir_q ? 17'(target) : -17'(target);
        end
      end else begin
        tick_d = tick_q + 32'h1;
      end
    end else begin
      spd_d = 17'sd0;
      tick_d = 32'h0;
    end
    case (state_q)
      ST_IDLE: begin
        if (trig && allowed) begin
          dir_d = fwd_mode;
          if (mode_act_q == 4'h0) begin
            pos_d = encoder_position;
            load_d = 1'b1;
            done_d = 1'b1;
          end else begin
            state_d = ST_APPROACH;
          end
        end
      end
      ST_APPROACH: begin
        if (origin_hit) begin
          state_d = ST_LEAVE;
          dir_d = ~dir_q;
        end else if (limit_hit) begin
          if (cfg_act_q[CFG_LIMIT] && mode_act_q <= MODE_LAST_SWITCH) begin
            state_d = ST_LIMIT;
          end else begin
            dir_d = ~dir_q;
          end
        end
      end
      ST_LEAVE: begin
        if (!origin_hit) begin
          state_d = ST_OFFSET;
          ofs_left_d = offset_q;
        end
      end
      ST_OFFSET: begin
        state_d = ST_IDLE;
        pos_d = encoder_position + ofs_left_q;
        load_d = cfg_act_q[CFG_STORAGE] && !cfg_act_q[CFG_ENC_TYPE];
        done_d = 1'b1;
      end
      ST_LIMIT: begin
        if (!pin_s.fwd_ot && !pin_s.rev_ot) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!cfg_act_q[CFG_ENABLE] || !position_mode) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      start_prev_q <= 1'b0;
      servo_prev_q <= 1'b0;
      dir_q <= 1'b0;
      offset_q <= 32'h0000_0000;
      pos_q <= 32'h0000_0000;
      load_q <= 1'b0;
      done_q <= 1'b0;
      spd_q <= 17'sd0;
      tick_q <= 32'h0000_0000;
      ofs_left_q <= 32'h0000_0000;
      motion <= '0;
    end else begin
      state_q <= state_d;
      start_prev_q <= start_prev_d;
      servo_prev_q <= servo_prev_d;
      dir_q <= dir_d;
      offset_q <= offset_d;
      pos_q <= pos_d;
      load_q <= load_d;
      done_q <= done_d;
      spd_q <= spd_d;
      tick_q <= tick_d;
      ofs_left_q <= ofs_left_d;
      motion.position <= pos_d;
      motion.position_load <= load_d;
      motion.speed <= spd_d;
      // busy also covers the completion cycle, so a one-cycle run still shows
      motion.homing_busy <= (state_d != ST_IDLE) || done_d;
      motion.homing_done <= done_d;
      motion.limit_state <= (state_d == ST_LIMIT);
    end
  end
endmodule : servo_homing_sequencer

//--- testbench/homing_props.sv
module homing_props
  import homing_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // drive context
  input wire logic position_mode,
  input wire logic positioning_complete_output,
  // pins and motion
  input wire homing_pkg::pins_t pins,
  input wire homing_pkg::motion_t motion
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // clocking
  // --------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // --------
  // checks
  // --------
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered next cycle");
  a_start_positioning_complete_output: assert property ($rose(motion.homing_busy) |-> $past(positioning_complete_output))
    else $error("homing began without positioning complete");
  a_start_mode: assert property ($rose(motion.homing_busy) |-> $past(position_mode))
    else $error("homing began outside position control");
  a_start_no_ot: assert property ($rose(motion.homing_busy) |-> !$past(pins.fwd_ot || pins.rev_ot))
    else $error("homing began under overtravel");
  a_done_pulse: assert property (motion.homing_done |=> !motion.homing_done)
    else $error("done pulse longer than one cycle");
  a_done_in_run: assert property (motion.homing_done |-> motion.homing_busy || $past(motion.homing_busy))
    else $error("done without a homing run");
  a_speed_cap: assert property ($signed(motion.speed) <= 17'sh0BB8 && $signed(motion.speed) >= -17'sh0BB8)
    else $error("speed beyond approach range");
  a_limit_cause: assert property ($rose(motion.limit_state) |-> $past(pins.fwd_ot || pins.rev_ot, 2))
    else $error("limit state without overtravel");
  a_limit_no_done: assert property (motion.limit_state |-> !motion.homing_done)
    else $error("done reported in limit state");
  // main scenarios reached
  c_done: cover property (motion.homing_done);
  c_limit: cover property ($rose(motion.limit_state));
  c_load: cover property (motion.position_load);
endmodule : homing_props

bind servo_homing_sequencer homing_props u_props (
  .clock, .rst, .read, .write, .waitrequest, .position_mode,
  .positioning_complete_output, .pins, .motion
);

//--- testbench/homing_far_side.sv
module homing_far_side
  import homing_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // motion command
  input wire homing_pkg::motion_t motion,
  // bench controls
  input wire logic load,
  input wire logic signed [31:0] load_val,
  input wire logic signed [31:0] org_pos,
  input wire logic signed [31:0] lim_pos,
  input wire logic [1:0] ot_force,
  // switches and encoder
  output logic origin,
  output logic fwd_ot,
  output logic rev_ot,
  output logic index,
  output logic [31:0] enc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [31:0] pos_q; // shaft position in counts
  // --------
  // shaft
  // --------
  // shaft integrates commanded speed each cycle
  always_ff @(posedge clock) begin
    if (rst || load) begin
      pos_q <= rst ? 32'sh0 : load_val;
    end else begin
      pos_q <= pos_q + 32'(motion.speed);
    end
  end
  // switches follow the shaft; origin window is wide to absorb overshoot
  assign origin = (pos_q >= org_pos) && (pos_q < org_pos + 32'sh9C40);
  assign fwd_ot = ot_force[1] || (pos_q >= lim_pos);
  assign rev_ot = ot_force[0] || (pos_q < -32'sh7A120);
  assign index = (pos_q[11:6] == 6'h00);
  assign enc = pos_q;
endmodule : homing_far_side

//--- testbench/servo_homing_sequencer_tb.sv
module servo_homing_sequencer_tb
  import homing_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // signals
  // --------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic power_up = 1'b0;
  logic servo_on = 1'b1;
  logic position_mode = 1'b1;
  logic positioning_complete_output = 1'b1;
  logic start = 1'b0;
  logic origin, fwd_ot, rev_ot, index;
  logic [31:0] enc;
  logic load = 1'b0;
  logic signed [31:0] load_val = 32'sh0;
  logic signed [31:0] org_pos = 32'sh186A0;
  logic signed [31:0] lim_pos = 32'sh1000_0000;
  logic [1:0] ot_force = 2'b00;
  logic busy_d = 1'b0;
  pins_t pins;
  motion_t motion;
  int err_count = 0;
  int tests_run = 0;
  int rises = 0;
  int dones = 0;
  int loads = 0;
  int spd, spd_max, spd_leave;
  logic [15:0] rst_tbl [9] = '{16'h0, 16'h0, 16'h0, 16'h05DC, 16'h001E, 16'h0, 16'h0, 16'h0064, 16'h0};
  assign pins = {start, origin, fwd_ot, rev_ot, index};
  // --------
  // instances
  // --------
  servo_homing_sequencer uut (
    .clock, .rst, .address, .read, .write, .writedata, .byteenable(4'hF), .readdata,
    .waitrequest, .power_up, .servo_on, .position_mode, .positioning_complete_output,
    .encoder_position(enc), .pins, .motion
  );
  homing_far_side far (
    .clock, .rst, .motion, .load, .load_val, .org_pos, .lim_pos, .ot_force,
    .origin, .fwd_ot, .rev_ot, .index, .enc
  );
  always #25 clock = ~clock;
  // counts runs, completions, loads and speeds seen
  always @(posedge clock) begin
    busy_d <= motion.homing_busy;
    spd = $signed(motion.speed);
    spd = (spd < 0) ? -spd : spd;
    if (motion.homing_busy === 1'b1 && busy_d === 1'b0) rises++;
    if (motion.homing_done === 1'b1) dones++;
    if (motion.position_load === 1'b1) loads++;
    if (motion.homing_busy === 1'b1 && spd > spd_max) spd_max = spd;
    if (motion.homing_busy === 1'b1 && origin === 1'b1 && spd != 0) spd_leave = spd;
  end
  // --------
  // tasks
  // --------
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_int(input string nm, input int e, input int g);
    tests_run++;
    if (g != e) begin
      err_count++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_int
  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] i, input logic [15:0] wd, output logic [31:0] rd);
    address <= {i, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0, wd};
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [3:0] i, input logic [15:0] v);
    logic [31:0] d;
    bus(1'b1, i, v, d);
  endtask : wr
  task automatic rchk(input logic [3:0] i, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, i, 16'h0, d);
    chk_val($sformatf("register %0d", i), e, d);
  endtask : rchk
  // new settings brought into force by a power cycle
  task automatic cfg(input logic [15:0] c, input logic [3:0] m);
    wr(REG_CONFIG, c);
    wr(REG_MODE, {12'h0, m});
    power_up <= 1'b1;
    @(posedge clock);
    power_up <= 1'b0;
    @(posedge clock);
  endtask : cfg
  task automatic place(input logic signed [31:0] p);
    load_val <= p;
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    @(posedge clock);
  endtask : place
  // trigger by start pin or servo-on edge, then count runs and completions
  task automatic home(input logic srv, input logic twice, input int eb, input int ed);
    int b, d, n;
    b = rises;
    d = dones;
    n = 0;
    repeat (twice ? 2 : 1) begin
      start <= ~srv;
      servo_on <= ~srv;
      repeat (8) @(posedge clock);
      start <= 1'b0;
      servo_on <= 1'b1;
      repeat (8) @(posedge clock);
    end
    while (dones == d && n < (ed > 0 ? 6000 : 400)) begin
      @(posedge clock);
      n++;
    end
    repeat (4) @(posedge clock);
    chk_int("homing runs", eb, rises - b);
    chk_int("homing completions", ed, dones - d);
  endtask : home
  // --------
  // sequence
  // --------
  initial begin
    int a, l, t, h, o;
    logic [31:0] e;
    void'($urandom(32'hF204));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 9; i++) rchk(4'(i), {16'h0, rst_tbl[i]});
    rchk(4'hF, 32'h0);
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 3000 : $urandom_range(3000);
      l = (k == 0) ? 200 : $urandom_range(200);
      t = (k == 0) ? 5000 : $urandom_range(5000);
      h = (k == 0) ? -9999 : $urandom_range(19998) - 9999;
      o = (k == 0) ? 9999 : $urandom_range(19998) - 9999;
      wr(REG_APPROACH, 16'(a));
      wr(REG_LEAVE, 16'(l));
      wr(REG_ACCEL, 16'(t));
      wr(REG_OFS_HI, 16'(h));
      wr(REG_OFS_LO, 16'(o));
      rchk(REG_APPROACH, 32'(a));
      rchk(REG_LEAVE, 32'(l));
      rchk(REG_ACCEL, 32'(t));
      rchk(REG_OFS_HI, {16'h0, 16'(h)});
      rchk(REG_OFFSET, 32'(h * 10000 + o));
    end
    wr(REG_APPROACH, 16'h0FA0);
    rchk(REG_APPROACH, 32'h0BB8);
    wr(REG_LEAVE, 16'h00C9);
    rchk(REG_LEAVE, 32'h00C8);
    wr(REG_LEAVE, 16'h001E);
    wr(REG_ACCEL, 16'h0);
    wr(REG_OFS_HI, 16'h0);
    wr(REG_OFS_LO, 16'h0);
    wr(REG_CONFIG, 16'h0005);
    home(1'b0, 1'b0, 0, 0);
    cfg(16'h0005, 4'h0);
    e = $urandom_range(32'h0FFF_FFFF);
    place(e);
    l = loads;
    home(1'b0, 1'b0, 1, 1);
    chk_val("position", e, motion.position);
    chk_int("position loads", 1, loads - l);
    rchk(REG_SINGLE, {16'h0, e[15:0]});
    rchk(REG_MULTI, {16'h0, e[31:16]});
    positioning_complete_output <= 1'b0;
    home(1'b0, 1'b0, 0, 0);
    positioning_complete_output <= 1'b1;
    position_mode <= 1'b0;
    home(1'b0, 1'b0, 0, 0);
    position_mode <= 1'b1;
    for (int s = 1; s < 3; s++) begin
      ot_force <= 2'(s);
      home(1'b0, 1'b0, 0, 0);
    end
    ot_force <= 2'b00;
    // origin far enough out that the approach reaches full speed
    org_pos <= 32'sh004C_4B40;
    cfg(16'h0015, 4'h1);
    place(32'sh0);
    spd_max = 0;
    spd_leave = 0;
    l = loads;
    home(1'b0, 1'b1, 1, 1);
    chk_int("approach speed", 3000, spd_max);
    chk_int("leave speed", 30, spd_leave);
    chk_int("position loads", 0, loads - l);
    org_pos <= -32'sh186A0;
    lim_pos <= 32'sh4E20;
    cfg(16'h0005, 4'h1);
    place(32'sh0);
    home(1'b0, 1'b0, 1, 1);
    cfg(16'h000D, 4'h1);
    place(32'sh0);
    home(1'b0, 1'b0, 1, 0);
    chk_val("limit state", 32'h1, {31'h0, motion.limit_state});
    place(32'sh0);
    repeat (8) @(posedge clock);
    chk_val("limit state", 32'h0, {31'h0, motion.limit_state});
    cfg(16'h0001, 4'h0);
    rchk(REG_SINGLE, 32'h0);
    rchk(REG_MULTI, 32'h0);
    cfg(16'h0003, 4'h0);
    home(1'b1, 1'b0, 1, 1);
    cfg(16'h0000, 4'h0);
    home(1'b0, 1'b0, 0, 0);
    results();
  end
  // hang guard well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    results();
  end
endmodule : servo_homing_sequencer_tb
